//--- common/ubk_pkg.sv
// package of register map, field layout and timing constants for the baud and break block
package ubk_pkg;
    // ----------------------------------------
    // register addresses on the memory bus
    // ----------------------------------------
    localparam logic [15:0] UBK_ADDR_CLK_SEL = 16'hFF56;
    localparam logic [15:0] UBK_ADDR_DIVIDER = 16'hFF57;
    localparam logic [15:0] UBK_ADDR_CTRL = 16'hFF58;
    // ----------------------------------------
    // reset values
    // ----------------------------------------
    localparam logic [3:0] UBK_RST_CLK_SEL = 4'h0;
    localparam logic [7:0] UBK_RST_DIVIDER = 8'hFF;
    localparam logic [7:0] UBK_RST_CTRL = 8'h16;
    // ----------------------------------------
    // control register field positions
    // ----------------------------------------
    localparam int UBK_BIT_RX_BUSY = 7;
    localparam int UBK_BIT_RX_TRIG = 6;
    localparam int UBK_BIT_TX_TRIG = 5;
    localparam int UBK_BIT_WIDTH_HI = 4;
    localparam int UBK_BIT_WIDTH_LO = 2;
    localparam int UBK_BIT_ORDER = 1;
    localparam int UBK_BIT_INVERT = 0;
    // ----------------------------------------
    // clock select and divider limits
    // ----------------------------------------
    localparam logic [3:0] UBK_SEL_MAX_POW = 4'hA;
    localparam logic [3:0] UBK_SEL_TIMER = 4'hB;
    localparam logic [7:0] UBK_DIV_MIN = 8'h08;
    // break widths: code 5 is shortest (13), codes 0..4 give 16..20
    localparam logic [4:0] UBK_BRK_BASE_LONG = 5'h10;
    localparam logic [4:0] UBK_BRK_BASE_SHORT = 5'h08;
    // received low run of at least this many bit times is a valid break
    localparam logic [4:0] UBK_BRK_RX_MIN = 5'h0B;
    // ----------------------------------------
    // fifo shape for the receive sample path
    // ----------------------------------------
    localparam int UBK_FIFO_WIDTH = 8;
    localparam int UBK_FIFO_DEPTH = 16;

    // register bus request bundle
    typedef struct packed {
        logic wr;
        logic rd;
        logic [15:0] addr;
        logic [7:0] wdata;
    } ubk_bus_s;

    // mode bits from the port mode register outside this block
    typedef struct packed {
        logic power;
        logic tx_en;
        logic rx_en;
    } ubk_mode_s;
endpackage

//--- hw/ubk_sync.sv
// three-stage synchroniser with agreement detection for pin inputs
`timescale 1ns/10ps
module ubk_sync
    import ubk_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    input wire logic i_async,
    output logic o_level
);
    logic s1_r;
    logic s2_r;
    logic s3_r;

    // ----------------------------------------
    // sampling chain, idle high
    // ----------------------------------------
    // first stage is read only by the second, so metastability stays contained
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s1_r <= 1'b1;
            s2_r <= 1'b1;
            s3_r <= 1'b1;
            o_level <= 1'b1;
        end else if (i_ce) begin
            s1_r <= i_async;
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (s2_r == s3_r) begin
                o_level <= s3_r;
            end
        end
    end
endmodule

//--- hw/ubk_fifo.sv
// parameterised flip-flop fifo with valid and ready on both sides
`timescale 1ns/10ps
module ubk_fifo
    import ubk_pkg::*;
#(
    parameter int WIDTH = UBK_FIFO_WIDTH,
    parameter int DEPTH = UBK_FIFO_DEPTH
)
(
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    input wire logic i_clear,
    input wire logic i_valid,
    output logic o_ready,
    input wire logic [WIDTH-1:0] i_data,
    output logic o_valid,
    input wire logic i_ready,
    output logic [WIDTH-1:0] o_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] wp_r;
    logic [AW-1:0] rp_r;
    logic [AW:0] cnt_r;
    logic push;
    logic pop;

    assign o_ready = (cnt_r != DEPTH[AW:0]);
    assign o_valid = (cnt_r != '0);
    assign o_data = mem_r[rp_r];
    assign push = i_valid && o_ready;
    assign pop = o_valid && i_ready;

    // ----------------------------------------
    // storage and pointers
    // ----------------------------------------
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end else if (i_ce) begin
            if (i_clear) begin
                wp_r <= '0;
                rp_r <= '0;
                cnt_r <= '0;
            end else begin
                if (push) begin
                    wp_r <= wp_r + 1'b1;
                end
                if (pop) begin
                    rp_r <= rp_r + 1'b1;
                end
                cnt_r <= cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
            end
        end
    end

    // data words carry no reset; they are only read when counted valid
    always_ff @(posedge i_ref_clk) begin
        if (i_ce && push && !i_clear) begin
            mem_r[wp_r] <= i_data;
        end
    end
endmodule

//--- hw/ubk_top.sv
// baud rate generation and sync break control of the async serial port
`timescale 1ns/10ps
// Function
// - clock select codes 0..10 give system clock over 2^code, 11 the timer
// - 8-bit divider divides base clock by k, k from 8 to 255
// - bit rate is the divider output halved
// - rewriting same clock select or divider value does not disturb traffic
// - refreshing control register restarts break reception; software must allow for it
// - busy flag bit 7 reads 1 during reception, clears on power/rx off or success
// - failed break reception keeps busy flag set; software re-arms reception
// - writing rx trigger starts reception; reads 0, clears on success
// - writing tx trigger sends a break; reads 0, clears at its end
// - width codes 5,6,7 give 13..15 bits, codes 0..4 give 16..20
// - bit order 0 is MSB first, 1 LSB first; change only while idle
// - inversion bit set drives transmit line inverted while powered; power off holds it high
// - power off stops the internal clock low and resets port logic
// - power off also clears busy flag and reception trigger
// - rx enable off resets reception, tx enable off resets transmission
module ubk_top
    import ubk_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    input wire logic i_bus_wr,
    input wire logic i_bus_rd,
    input wire logic [15:0] i_bus_addr,
    input wire logic [7:0] i_bus_wdata,
    output logic [7:0] o_bus_rdata,
    input wire logic i_port_power_enable,
    input wire logic i_tx_enable_bit,
    input wire logic i_rx_enable_bit,
    input wire logic i_timer_output_source,
    input wire logic i_serial_in_line,
    input wire logic i_tx_data_bit,
    input wire logic i_sample_ready,
    output logic o_serial_out_line,
    output logic o_baud_tick,
    output logic o_bit_order_select,
    output logic o_tx_done,
    output logic o_rx_done,
    output logic o_sample_valid,
    output logic o_sample_bit
);
    typedef enum logic [1:0] {TX_IDLE, TX_BREAK} ubk_tx_e;
    typedef enum logic [1:0] {RX_IDLE, RX_WAIT_LOW, RX_COUNT} ubk_rx_e;

    ubk_bus_s bus;
    ubk_mode_s mode;
    ubk_tx_e tx_st_r;
    ubk_rx_e rx_st_r;
    logic [3:0] clk_sel_r;
    logic [7:0] divider_r;
    logic [2:0] width_r;
    logic bit_order_r;
    logic invert_r;
    logic rx_trig_r;
    logic rx_busy_r;
    logic [10:0] pre_r;
    logic [10:0] pre_nxt;
    logic tmr_d_r;
    logic base_tick;
    logic [7:0] div_cnt_r;
    logic half_r;
    logic bit_tick_r;
    logic [4:0] tx_cnt_r;
    logic [4:0] rx_cnt_r;
    logic line_in;
    logic rx_on;
    logic tx_on;
    logic tx_start;
    logic rx_start;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [UBK_FIFO_WIDTH-1:0] fifo_out_data;
    logic [UBK_FIFO_WIDTH-1:0] shift_r;
    logic [2:0] shift_cnt_r;
    logic ctrl_wr;

    assign bus = '{wr: i_bus_wr, rd: i_bus_rd, addr: i_bus_addr, wdata: i_bus_wdata};
    assign mode = '{power: i_port_power_enable, tx_en: i_tx_enable_bit,
                    rx_en: i_rx_enable_bit};
    assign rx_on = mode.power && mode.rx_en;
    assign tx_on = mode.power && mode.tx_en;
    assign ctrl_wr = bus.wr && (bus.addr == UBK_ADDR_CTRL);
    assign tx_start = ctrl_wr && bus.wdata[UBK_BIT_TX_TRIG] && tx_on;
    assign rx_start = ctrl_wr && bus.wdata[UBK_BIT_RX_TRIG] && rx_on;

    // number of bit times for a break width code
    function automatic logic [4:0] brk_bits(input logic [2:0] code);
        if (code >= 3'h5) begin
            brk_bits = UBK_BRK_BASE_SHORT + {2'b00, code};
        end else begin
            brk_bits = UBK_BRK_BASE_LONG + {2'b00, code};
        end
    endfunction

    // ----------------------------------------
    // synchronised receive pin
    // ----------------------------------------
    ubk_sync u_sync (
        .i_ref_clk(i_ref_clk),
        .i_rst_n(i_rst_n),
        .i_ce(i_ce),
        .i_async(i_serial_in_line),
        .o_level(line_in)
    );

    // ----------------------------------------
    // register writes
    // ----------------------------------------
    // plain stores; an unchanged value leaves the dividers untouched
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            clk_sel_r <= UBK_RST_CLK_SEL;
            divider_r <= UBK_RST_DIVIDER;
            width_r <= UBK_RST_CTRL[UBK_BIT_WIDTH_HI:UBK_BIT_WIDTH_LO];
            bit_order_r <= UBK_RST_CTRL[UBK_BIT_ORDER];
            invert_r <= UBK_RST_CTRL[UBK_BIT_INVERT];
        end else if (i_ce && bus.wr) begin
            if (bus.addr == UBK_ADDR_CLK_SEL) begin
                clk_sel_r <= bus.wdata[3:0];
            end
            if (bus.addr == UBK_ADDR_DIVIDER) begin
                divider_r <= bus.wdata;
            end
            if (bus.addr == UBK_ADDR_CTRL) begin
                width_r <= bus.wdata[UBK_BIT_WIDTH_HI:UBK_BIT_WIDTH_LO];
                bit_order_r <= bus.wdata[UBK_BIT_ORDER];
                invert_r <= bus.wdata[UBK_BIT_INVERT];
            end
        end
    end

    // ----------------------------------------
    // register read mux, registered
    // ----------------------------------------
    // triggers always read back as zero
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_bus_rdata <= 8'h00;
        end else if (i_ce) begin
            if (bus.rd && bus.addr == UBK_ADDR_CLK_SEL) begin
                o_bus_rdata <= {4'h0, clk_sel_r};
            end else if (bus.rd && bus.addr == UBK_ADDR_DIVIDER) begin
                o_bus_rdata <= divider_r;
            end else if (bus.rd && bus.addr == UBK_ADDR_CTRL) begin
                o_bus_rdata <= {rx_busy_r, 2'b00, width_r, bit_order_r, invert_r};
            end else begin
                o_bus_rdata <= 8'h00;
            end
        end
    end

    // ----------------------------------------
    // base clock prescaler
    // ----------------------------------------
    // the tick is one cycle where the selected prescaler bit rises
    assign pre_nxt = pre_r + 11'h001;
    always_comb begin
        base_tick = 1'b0;
        if (clk_sel_r == 4'h0) begin
            base_tick = 1'b1;
        end else if (clk_sel_r <= UBK_SEL_MAX_POW) begin
            base_tick = !pre_r[clk_sel_r - 4'h1] && pre_nxt[clk_sel_r - 4'h1];
        end else if (clk_sel_r == UBK_SEL_TIMER) begin
            base_tick = i_timer_output_source && !tmr_d_r;
        end
    end

    // power off freezes the clock chain low
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pre_r <= 11'h000;
            tmr_d_r <= 1'b0;
        end else if (i_ce) begin
            tmr_d_r <= i_timer_output_source;
            pre_r <= mode.power ? pre_nxt : 11'h000;
        end
    end

    // ----------------------------------------
    // 8-bit divider and final halving
    // ----------------------------------------
    // values below the minimum are clamped rather than left undefined
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            div_cnt_r <= 8'h00;
            half_r <= 1'b0;
            bit_tick_r <= 1'b0;
        end else if (i_ce) begin
            bit_tick_r <= 1'b0;
            if (!mode.power || !(mode.tx_en || mode.rx_en)) begin
                div_cnt_r <= 8'h00;
                half_r <= 1'b0;
            end else if (base_tick) begin
                if (div_cnt_r >= ((divider_r < UBK_DIV_MIN) ? UBK_DIV_MIN : divider_r)
                        - 8'h01) begin
                    div_cnt_r <= 8'h00;
                    half_r <= !half_r;
                    bit_tick_r <= half_r;
                end else begin
                    div_cnt_r <= div_cnt_r + 8'h01;
                end
            end
        end
    end

    // ----------------------------------------
    // break transmission
    // ----------------------------------------
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            tx_st_r <= TX_IDLE;
            tx_cnt_r <= 5'h00;
            o_tx_done <= 1'b0;
        end else if (i_ce) begin
            o_tx_done <= 1'b0;
            if (!tx_on) begin
                tx_st_r <= TX_IDLE;
                tx_cnt_r <= 5'h00;
            end else begin
                case (tx_st_r)
                    TX_IDLE: begin
                        if (tx_start) begin
                            tx_st_r <= TX_BREAK;
                            tx_cnt_r <= brk_bits(bus.wdata[UBK_BIT_WIDTH_HI:UBK_BIT_WIDTH_LO]);
                        end
                    end
                    TX_BREAK: begin
                        if (bit_tick_r) begin
                            if (tx_cnt_r == 5'h01) begin
                                tx_st_r <= TX_IDLE;
                                o_tx_done <= 1'b1;
                            end
                            tx_cnt_r <= tx_cnt_r - 5'h01;
                        end
                    end
                    default: begin
                        tx_st_r <= TX_IDLE;
                    end
                endcase
            end
        end
    end

    // line drive: idle high when powered off, the inversion bit during break, else shifter data (high with tx off) xor inversion bit
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_serial_out_line <= 1'b1;
            o_baud_tick <= 1'b0;
            o_bit_order_select <= UBK_RST_CTRL[UBK_BIT_ORDER];
        end else if (i_ce) begin
            o_baud_tick <= bit_tick_r;
            o_bit_order_select <= bit_order_r;
            if (!mode.power) begin
                o_serial_out_line <= 1'b1;
            end else if (tx_st_r == TX_BREAK) begin
                o_serial_out_line <= invert_r;
            end else begin
                o_serial_out_line <= (tx_on ? i_tx_data_bit : 1'b1) ^ invert_r;
            end
        end
    end

    // ----------------------------------------
    // break reception
    // ----------------------------------------
    // a write of the trigger mid-reception re-arms from scratch
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rx_st_r <= RX_IDLE;
            rx_cnt_r <= 5'h00;
            rx_trig_r <= 1'b0;
            rx_busy_r <= 1'b0;
            o_rx_done <= 1'b0;
        end else if (i_ce) begin
            o_rx_done <= 1'b0;
            if (!rx_on) begin
                rx_st_r <= RX_IDLE;
                rx_trig_r <= 1'b0;
                rx_busy_r <= 1'b0;
                rx_cnt_r <= 5'h00;
            end else if (rx_start) begin
                rx_st_r <= RX_WAIT_LOW;
                rx_trig_r <= 1'b1;
                rx_busy_r <= 1'b1;
                rx_cnt_r <= 5'h00;
            end else begin
                case (rx_st_r)
                    RX_IDLE: begin
                    end
                    RX_WAIT_LOW: begin
                        if (!line_in) begin
                            rx_st_r <= RX_COUNT;
                            rx_cnt_r <= 5'h00;
                        end
                    end
                    RX_COUNT: begin
                        if (line_in) begin
                            if (rx_cnt_r >= UBK_BRK_RX_MIN) begin
                                rx_st_r <= RX_IDLE;
                                rx_trig_r <= 1'b0;
                                rx_busy_r <= 1'b0;
                                o_rx_done <= 1'b1;
                            end else begin
                                rx_st_r <= RX_IDLE;
                            end
                        end else if (bit_tick_r && rx_cnt_r != 5'h1F) begin
                            rx_cnt_r <= rx_cnt_r + 5'h01;
                        end
                    end
                    default: begin
                        rx_st_r <= RX_IDLE;
                    end
                endcase
            end
        end
    end

    // ----------------------------------------
    // receive sample path through the fifo
    // ----------------------------------------
    // line samples are packed per bit tick; when the fifo is full the
    // packer holds, so a stalled reader drops later samples, not old ones
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            shift_r <= '0;
            shift_cnt_r <= 3'h0;
        end else if (i_ce) begin
            if (!rx_on) begin
                shift_cnt_r <= 3'h0;
            end else if (bit_tick_r && fifo_in_ready) begin
                shift_r <= {shift_r[UBK_FIFO_WIDTH-2:0], line_in};
                shift_cnt_r <= shift_cnt_r + 3'h1;
            end
        end
    end

    ubk_fifo #(
        .WIDTH(UBK_FIFO_WIDTH),
        .DEPTH(UBK_FIFO_DEPTH)
    ) u_fifo (
        .i_ref_clk(i_ref_clk),
        .i_rst_n(i_rst_n),
        .i_ce(i_ce),
        .i_clear(!rx_on),
        .i_valid(bit_tick_r && fifo_in_ready && shift_cnt_r == 3'h7 && rx_on),
        .o_ready(fifo_in_ready),
        .i_data({shift_r[UBK_FIFO_WIDTH-2:0], line_in}),
        .o_valid(fifo_out_valid),
        .i_ready(i_sample_ready && !o_sample_valid),
        .o_data(fifo_out_data)
    );

    // output stage register: parity of one word, valid for a single cycle
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_sample_valid <= 1'b0;
            o_sample_bit <= 1'b0;
        end else if (i_ce) begin
            if (o_sample_valid) begin
                o_sample_valid <= 1'b0;
            end else if (fifo_out_valid && i_sample_ready) begin
                o_sample_valid <= 1'b1;
                o_sample_bit <= ^fifo_out_data;
            end
        end
    end
endmodule

//--- verification/ubk_remote_node.sv
// remote node model driving the serial input line
`timescale 1ns/10ps
module ubk_remote_node (
    input wire logic i_ref_clk,
    output logic o_line
);
    // line has a pull-up, so it idles high between break fields
    initial o_line = 1'b1;
    // a low run of cyc clock cycles; its length decides good or failed break
    task automatic send_low(input int cyc);
        repeat (cyc) @(negedge i_ref_clk) o_line = 1'b0;
        @(negedge i_ref_clk) o_line = 1'b1;
    endtask
endmodule

//--- verification/ubk_top_properties.sv
// concurrent checks on the ports of the baud and break block
`timescale 1ns/10ps
module ubk_top_properties
    import ubk_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    input wire logic i_bus_wr,
    input wire logic i_bus_rd,
    input wire logic [15:0] i_bus_addr,
    input wire logic [7:0] i_bus_wdata,
    input wire logic [7:0] o_bus_rdata,
    input wire logic i_port_power_enable,
    input wire logic i_tx_enable_bit,
    input wire logic o_serial_out_line,
    input wire logic o_baud_tick,
    input wire logic o_tx_done,
    input wire logic o_rx_done,
    input wire logic i_sample_ready,
    input wire logic o_sample_valid
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);
    // ----
    // control register accesses
    // ----
    sequence s_ctrl_rd;
        i_ce && i_bus_rd && i_bus_addr == UBK_ADDR_CTRL;
    endsequence
    sequence s_tx_trig;
        i_ce && i_bus_wr && i_bus_addr == UBK_ADDR_CTRL && i_bus_wdata[5]
            && i_port_power_enable && i_tx_enable_bit;
    endsequence
    property p_trig_zero;
        s_ctrl_rd |=> o_bus_rdata[6:5] == 2'h0;
    endproperty
    a_trig_zero: assert property (p_trig_zero) else $error("trigger bit read as 1");
    property p_off_busy;
        (!i_port_power_enable [*2]) ##0 s_ctrl_rd |=> !o_bus_rdata[7];
    endproperty
    a_off_busy: assert property (p_off_busy) else $error("busy flag set while off");
    // break level appears two cycles after the trigger write
    property p_brk_level;
        s_tx_trig |-> ##2 o_serial_out_line == $past(i_bus_wdata[0], 2);
    endproperty
    a_brk_level: assert property (p_brk_level) else $error("break level wrong");
    // ----
    // power, ticks and completion pulses
    // ----
    property p_off_idle;
        !i_port_power_enable [*2] |-> o_serial_out_line;
    endproperty
    a_off_idle: assert property (p_off_idle) else $error("line low while off");
    // the tick port lags the internal tick by one cycle, so power must be off for three
    property p_off_notick;
        !i_port_power_enable [*3] |-> !o_baud_tick;
    endproperty
    a_off_notick: assert property (p_off_notick) else $error("tick while off");
    // shortest bit time is sixteen cycles (code 0, k of 8, halved)
    property p_tick_gap;
        o_baud_tick |=> !o_baud_tick [*8];
    endproperty
    a_tick_gap: assert property (p_tick_gap) else $error("ticks too close");
    property p_tx_pulse;
        o_tx_done |=> !o_tx_done;
    endproperty
    a_tx_pulse: assert property (p_tx_pulse) else $error("tx done too long");
    property p_rx_pulse;
        o_rx_done |=> !o_rx_done;
    endproperty
    a_rx_pulse: assert property (p_rx_pulse) else $error("rx done too long");
    property p_tx_off;
        !i_tx_enable_bit [*2] |-> !o_tx_done;
    endproperty
    a_tx_off: assert property (p_tx_off) else $error("tx done while disabled");
    // a held-off consumer never sees a sample pulse
    property p_sample_hold;
        !i_sample_ready |=> !o_sample_valid;
    endproperty
    a_sample_hold: assert property (p_sample_hold) else $error("sample pulse while not ready");
endmodule
bind ubk_top ubk_top_properties chk_u (.*);

//--- verification/uart_baud_and_break_control_bench.sv
// self-checking bench for the baud and break block
`timescale 1ns/10ps
module uart_baud_and_break_control_bench
    import ubk_pkg::*;
();
    logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, pwr = 1'b0, txe = 1'b0, rxe = 1'b0;
    logic tmr = 1'b0, txd = 1'b1, srdy = 1'b1, sin, line, tick, bos, txdn, rxdn, sval;
    logic [15:0] addr = 16'h0000;
    logic [7:0] wdata = 8'h00, rdata;
    int err_count = 0, checks = 0;
    ubk_top dut_u (.i_ref_clk(clk), .i_rst_n(rst_n), .i_ce(1'b1), .i_bus_wr(wr), .i_bus_rd(rd),
        .i_bus_addr(addr), .i_bus_wdata(wdata), .o_bus_rdata(rdata), .i_port_power_enable(pwr),
        .i_tx_enable_bit(txe), .i_rx_enable_bit(rxe), .i_timer_output_source(tmr),
        .i_serial_in_line(sin), .i_tx_data_bit(txd), .i_sample_ready(srdy),
        .o_serial_out_line(line), .o_baud_tick(tick), .o_bit_order_select(bos),
        .o_tx_done(txdn), .o_rx_done(rxdn), .o_sample_valid(sval), .o_sample_bit());
    ubk_remote_node node_u (.i_ref_clk(clk), .o_line(sin));
    // clock and a timer output with a rising edge every two cycles
    always #4 clk = ~clk;
    always @(negedge clk) tmr <= ~tmr;
    // ----
    // shared tasks
    // ----
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic conclude;
        $display("checks=%0d err_count=%0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // strobes last one cycle, driven and released at falling edges
    task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
        @(negedge clk) {addr, wdata, wr} = {a, d, 1'b1};
        @(negedge clk) wr = 1'b0;
    endtask
    task automatic rd_reg(input logic [15:0] a, output logic [7:0] d);
        @(negedge clk) {addr, rd} = {a, 1'b1};
        @(negedge clk) rd = 1'b0;
        d = rdata;
    endtask
    // w picks tick, tx done or rx done; a hang ends the run
    task automatic wait_hi(input int w, input int lim, output int n);
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while ((w == 0 ? tick : w == 1 ? txdn : rxdn) !== 1'b1 && n < lim);
        if (n >= lim) begin
            check(16'h0, 16'h1);
            conclude();
        end
    endtask
    // ----
    // scenarios
    // ----
    task automatic t_reset;
        logic [7:0] d;
        rd_reg(UBK_ADDR_CLK_SEL, d);
        check(d, 16'h00);
        rd_reg(UBK_ADDR_DIVIDER, d);
        check(d, 16'hFF);
        rd_reg(UBK_ADDR_CTRL, d);
        check(d, 16'h16);
        rd_reg(16'hFF59, d);
        check(d, 16'h00);
        check(bos, 16'h1);
        $display("reset test done");
    endtask
    task automatic t_baud;
        logic [3:0] sel[4] = '{4'h0, 4'h1, 4'hB, 4'h0};
        logic [7:0] k[4] = '{8'hFF, 8'h09, 8'h08, 8'h08};
        int exp[4] = '{510, 36, 32, 16};
        int n;
        for (int i = 0; i < 4; i++) begin
            @(negedge clk) {pwr, txe, rxe} = 3'b000;
            wr_reg(UBK_ADDR_CLK_SEL, {4'h0, sel[i]});
            wr_reg(UBK_ADDR_DIVIDER, k[i]);
            {pwr, txe} = 2'b11;
            wait_hi(0, 600, n);
            wait_hi(0, 600, n);
            check(16'(n), 16'(exp[i]));
        end
        // refresh with same values must not move the tick; four write cycles included
        wait_hi(0, 600, n);
        wr_reg(UBK_ADDR_DIVIDER, 8'h08);
        wr_reg(UBK_ADDR_CLK_SEL, 8'h00);
        wait_hi(0, 600, n);
        check(16'(n + 4), 16'd16);
        $display("baud test done");
    endtask
    task automatic t_break_tx;
        int n;
        for (int c = 0; c < 8; c++) begin
            wr_reg(UBK_ADDR_CTRL, 8'h22 | 8'(c << 2));
            n = 0;
            for (int j = 0; j < 400 && txdn !== 1'b1; j++) begin
                @(negedge clk) n += int'(tick === 1'b1);
                if (j == 8) check(line, 16'h0);
            end
            check(16'(n), c > 4 ? 16'(c + 8) : 16'(c + 16));
            if (txdn !== 1'b1) begin
                check(16'h0, 16'h1);
                conclude();
            end
            @(negedge clk) check(line, 16'h1);
        end
        // inversion and bit order may only change with both directions off
        txe = 1'b0;
        wr_reg(UBK_ADDR_CTRL, 8'h15);
        txe = 1'b1;
        wr_reg(UBK_ADDR_CTRL, 8'h35);
        wait_hi(1, 400, n);
        @(negedge clk) check(line, 16'h0);
        check(bos, 16'h0);
        txe = 1'b0;
        wr_reg(UBK_ADDR_CTRL, 8'h16);
        txe = 1'b1;
        $display("break transmit test done");
    endtask
    task automatic t_break_rx;
        logic [7:0] d;
        int n;
        rxe = 1'b1;
        wr_reg(UBK_ADDR_CTRL, 8'h56);
        rd_reg(UBK_ADDR_CTRL, d);
        check(d, 16'h96);
        node_u.send_low(208);
        wait_hi(2, 40, n);
        rd_reg(UBK_ADDR_CTRL, d);
        check(d, 16'h16);
        // refresh of the control value re-arms; a short low run must fail
        wr_reg(UBK_ADDR_CTRL, 8'h56);
        srdy = 1'b0;
        node_u.send_low(80);
        n = 0;
        repeat (40) @(negedge clk) n += int'(rxdn === 1'b1) + int'(sval === 1'b1);
        srdy = 1'b1;
        rd_reg(UBK_ADDR_CTRL, d);
        check({d, 8'(n)}, 16'h9600);
        rxe = 1'b0;
        rd_reg(UBK_ADDR_CTRL, d);
        check(d, 16'h16);
        rxe = 1'b1;
        wr_reg(UBK_ADDR_CTRL, 8'h56);
        pwr = 1'b0;
        rd_reg(UBK_ADDR_CTRL, d);
        check(d, 16'h16);
        $display("break receive test done");
    endtask
    // reset for twelve cycles, then the scenarios in turn
    initial begin
        repeat (12) @(negedge clk);
        rst_n = 1'b1;
        t_reset();
        t_baud();
        t_break_tx();
        t_break_rx();
        conclude();
    end
endmodule
